// ===== rtl/rtc_system_timer.sv
// real-time clock / system timer: 23-bit down counter with reload
// assumes rst is the power-on reset and the sfr port is on core_clk
//
// Function
// - counter is 23 bits: 7-bit prescaler low, 16-bit down counter high
// - counter held at all zeros while timer enable is zero
// - enable written one loads reload bytes and all-ones prescaler
// - at all zeros counter reloads and underflow flag sets
// - high reload byte is bits 22:15, low reload byte bits 14:7
// - crystal or external cpu clock: timer uses cpu clock
// - source select bits 6:5 honoured only for internal cpu oscillators
// - codes 00..10 pick external input, 11 internal oscillator path
// - source select writes ignored while enabled; software clears first
// - interrupt needs local, shared and global enables all set
// - underflow flag wakes the chip from power-down
// - only power-on reset returns timer and registers to defaults
// - timer power-down bit stops and clears timer regardless of enable
// - underflow flag in bit 7 sets at zero, sticks, software clears
// - flag stays readable so software can tell shared interrupt apart
// - control at d1h: enable 0, irq enable 1, select 6:5, flag 7
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_system_timer #(
   parameter int PRE_W = 7,
   parameter int HI_W  = 16
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [7:0]        sfr_addr,
   input  wire logic              sfr_wr,
   input  wire logic              sfr_rd,
   input  wire logic [7:0]        sfr_wdata,
   output logic [7:0]             sfr_rdata,
   input  wire logic              ext_clock_in,
   input  wire logic              cpu_clk_en,
   input  wire logic              int_osc_tick,
   input  wire logic              int_osc_div_tick,
   input  wire rtc_pkg::osc_sel_t cpu_oscillator_select,
   input  wire logic              rc_clock_option,
   input  wire logic              timer_power_down,
   input  wire logic              shared_wdog_timer_irq_enable,
   input  wire logic              global_irq_enable,
   output logic                   timer_irq,
   output logic                   wake_request,
   output logic [PRE_W+HI_W-1:0]  timer_count
);
   import rtc_pkg::*;

   localparam int CNT_W = PRE_W + HI_W;

   ////////////////////////////////////////////////////////////////////
   // declarations

   logic [7:0]       reload_high_byte_q;
   logic [7:0]       reload_low_byte_q;
   logic             timer_enable_q;
   logic             timer_irq_enable_q;
   src_sel_t         source_select_q;
   logic             underflow_flag_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   tmr_state_t       state_q;
   tmr_state_t       state_d;
   logic             timer_tick;
   logic [7:0]       rdata_d;

   // reload image used by both start and wrap
   function automatic logic [CNT_W-1:0] reload_image(input logic [7:0] hi,
                                                     input logic [7:0] lo);
      reload_image = {hi, lo, `RTC_PRESCALE_ONES};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // register port decode

   wire wr_ctrl = sfr_wr & (sfr_addr == `RTC_CTRL_ADDR);
   wire wr_hi   = sfr_wr & (sfr_addr == `RTC_RELOAD_HI_ADDR);
   wire wr_lo   = sfr_wr & (sfr_addr == `RTC_RELOAD_LO_ADDR);
   wire rd_ctrl = sfr_rd & (sfr_addr == `RTC_CTRL_ADDR);
   wire rd_hi   = sfr_rd & (sfr_addr == `RTC_RELOAD_HI_ADDR);
   wire rd_lo   = sfr_rd & (sfr_addr == `RTC_RELOAD_LO_ADDR);

   // next control bits
   wire en_d    = wr_ctrl ? sfr_wdata[`RTC_EN_BIT] : timer_enable_q;
   wire ie_d    = wr_ctrl ? sfr_wdata[`RTC_IE_BIT] : timer_irq_enable_q;
   wire sel_wr  = wr_ctrl & ~timer_enable_q;
   wire [1:0] sel_wdata = sfr_wdata[`RTC_SEL_HI_BIT:`RTC_SEL_LO_BIT];
   wire flag_clr = wr_ctrl & ~sfr_wdata[`RTC_FLAG_BIT];

   // control register image, reserved bits read zero
   wire [7:0] ctrl_image = {underflow_flag_q, source_select_q, 3'h0,
                            timer_irq_enable_q, timer_enable_q};

   ////////////////////////////////////////////////////////////////////
   // timer control sequencing

   // counter runs only when enabled and not powered down
   wire run_d    = en_d & ~timer_power_down;
   wire start    = run_d & (state_q == TMR_OFF);
   wire wrap     = timer_tick & (state_q == TMR_RUN) & run_d &
                   (count_q == '0);
   wire step     = timer_tick & (state_q == TMR_RUN) & run_d &
                   (count_q != '0);

   // state: off until started, back to off when stopped
   always_comb begin
      state_d = state_q;
      case (state_q)
         TMR_OFF: begin
            if (run_d) begin
               state_d = TMR_RUN;
            end
         end
         TMR_RUN: begin
            if (!run_d) begin
               state_d = TMR_OFF;
            end
         end
         default: begin
            state_d = TMR_OFF;
         end
      endcase
   end

   // counter next value: clear, load, reload or decrement
   always_comb begin
      if (!run_d) begin
         count_d = '0;
      end else if (start || wrap) begin
         count_d = reload_image(reload_high_byte_q, reload_low_byte_q);
      end else if (step) begin
         count_d = count_q - CNT_W'(1);
      end else begin
         count_d = count_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // clock source selection

   rtc_clock_select u_clock_select (
      .core_clk              (core_clk),
      .rst                   (rst),
      .ext_clock_in          (ext_clock_in),
      .cpu_clk_en            (cpu_clk_en),
      .int_osc_tick          (int_osc_tick),
      .int_osc_div_tick      (int_osc_div_tick),
      .cpu_oscillator_select (cpu_oscillator_select),
      .rc_clock_option       (rc_clock_option),
      .source_select         (source_select_q),
      .timer_tick            (timer_tick)
   );

   ////////////////////////////////////////////////////////////////////
   // registers, reset only by power-on reset

   // reload bytes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reload_high_byte_q <= `RTC_RELOAD_RST;
         reload_low_byte_q  <= `RTC_RELOAD_RST;
      end else begin
         if (wr_hi) begin
            reload_high_byte_q <= sfr_wdata;
         end
         if (wr_lo) begin
            reload_low_byte_q <= sfr_wdata;
         end
      end
   end

   // control bits
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timer_enable_q     <= 1'b0;
         timer_irq_enable_q <= 1'b0;
         source_select_q    <= `RTC_SEL_RST;
      end else begin
         timer_enable_q     <= en_d;
         timer_irq_enable_q <= ie_d;
         if (sel_wr) begin
            source_select_q <= sel_wdata;
         end
      end
   end

   // sticky underflow flag, set beats software clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         underflow_flag_q <= 1'b0;
      end else if (wrap) begin
         underflow_flag_q <= 1'b1;
      end else if (flag_clr) begin
         underflow_flag_q <= 1'b0;
      end
   end

   // counter and state; nothing here looks at chip power-down
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_q <= '0;
         state_q <= TMR_OFF;
      end else begin
         count_q <= count_d;
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data and outputs

   // read mux, unmapped addresses read zero
   assign rdata_d = rd_ctrl ? ctrl_image :
                    rd_hi   ? reload_high_byte_q :
                    rd_lo   ? reload_low_byte_q :
                    `RTC_RDATA_RST;

   // outputs straight from flops
   wire irq_d = underflow_flag_q & timer_irq_enable_q &
                shared_wdog_timer_irq_enable & global_irq_enable;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sfr_rdata    <= `RTC_RDATA_RST;
         timer_irq    <= 1'b0;
         wake_request <= 1'b0;
         timer_count  <= '0;
      end else begin
         sfr_rdata    <= rdata_d;
         timer_irq    <= irq_d;
         wake_request <= underflow_flag_q;
         timer_count  <= count_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_running;
      (state_q == TMR_RUN) && run_d;
   endsequence

   sequence s_wrap_point;
      s_running ##0 (timer_tick && count_q == '0);
   endsequence

   property p_hold_zero;
      !run_d |=> (count_q == '0);
   endproperty
   a_hold_zero: assert property (p_hold_zero)
      else $error("counter not zero while stopped");

   property p_start_load;
      start |=> (count_q == {$past(reload_high_byte_q), $past(reload_low_byte_q),
                             7'h7f});
   endproperty
   a_start_load: assert property (p_start_load)
      else $error("start did not load reload image");

   property p_wrap_reload;
      s_wrap_point |=> underflow_flag_q &&
         (count_q[CNT_W-1:PRE_W] == {$past(reload_high_byte_q),
                                     $past(reload_low_byte_q)}) &&
         (count_q[PRE_W-1:0] == 7'h7f);
   endproperty
   a_wrap_reload: assert property (p_wrap_reload)
      else $error("wrap did not reload and flag");

   property p_step;
      (s_running ##0 (timer_tick && count_q != '0)) |=>
         (count_q == $past(count_q) - CNT_W'(1));
   endproperty
   a_step: assert property (p_step)
      else $error("counter did not step by one");

   property p_idle_stable;
      (s_running ##0 !timer_tick) |=> $stable(count_q);
   endproperty
   a_idle_stable: assert property (p_idle_stable)
      else $error("counter moved without a tick");

   property p_sel_locked;
      (wr_ctrl && timer_enable_q) |=> $stable(source_select_q);
   endproperty
   a_sel_locked: assert property (p_sel_locked)
      else $error("source select changed while enabled");

   property p_flag_sticky;
      (underflow_flag_q && !flag_clr) |=> underflow_flag_q;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("underflow flag dropped without a clear");

   property p_irq_gate;
      ##1 (timer_irq == ($past(underflow_flag_q) && $past(timer_irq_enable_q) &&
           $past(shared_wdog_timer_irq_enable) && $past(global_irq_enable)));
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt does not follow its enables");

   property p_wake;
      underflow_flag_q [*2] |-> wake_request;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake request missing with flag set");

   property p_ctrl_read;
      rd_ctrl |=> (sfr_rdata[7] == $past(underflow_flag_q)) &&
                  (sfr_rdata[4:2] == 3'h0) &&
                  (sfr_rdata[0] == $past(timer_enable_q));
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control read image wrong");

   // select field is taken from any control write made while the enable bit is clear
   property p_sel_write;
      (wr_ctrl && !timer_enable_q) |=> (source_select_q == $past(sel_wdata));
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("source select not taken while stopped");

   // software clear drops the flag unless a wrap lands in the same cycle
   property p_flag_clear;
      (flag_clr && !wrap) |=> !underflow_flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("underflow flag not cleared by software");

   // no wake request without the flag behind it
   property p_wake_clear;
      !underflow_flag_q |=> !wake_request;
   endproperty
   a_wake_clear: assert property (p_wake_clear)
      else $error("wake request without underflow flag");

   // power-down stops and clears the counter whatever the enable holds
   property p_power_off;
      timer_power_down |=> (state_q == TMR_OFF) && (count_q == '0);
   endproperty
   a_power_off: assert property (p_power_off)
      else $error("timer still running while powered down");

   // read data returns to zero once the read strobe is gone
   property p_rdata_idle;
      !sfr_rd |=> (sfr_rdata == `RTC_RDATA_RST);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not idle without a read");

   // reload high byte reads back what was stored
   property p_hi_read;
      rd_hi |=> (sfr_rdata == $past(reload_high_byte_q));
   endproperty
   a_hi_read: assert property (p_hi_read)
      else $error("reload high byte read back wrong");
endmodule

// ===== rtl/rtc_cfg.svh
// constants for the real-time clock / system timer
// assumes inclusion by bare name from every file that needs them
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// register addresses on the special function register port
`define RTC_CTRL_ADDR      8'hd1
`define RTC_RELOAD_HI_ADDR 8'hd2
`define RTC_RELOAD_LO_ADDR 8'hd3
// control register field positions
`define RTC_EN_BIT         0
`define RTC_IE_BIT         1
`define RTC_SEL_LO_BIT     5
`define RTC_SEL_HI_BIT     6
`define RTC_FLAG_BIT       7
// reset values
`define RTC_SEL_RST        2'h3
`define RTC_RELOAD_RST     8'h00
`define RTC_RDATA_RST      8'h00
// prescaler fill on every load
`define RTC_PRESCALE_ONES  7'h7f
// cpu oscillator codes and source select code
`define RTC_FOSC_RC        3'h3
`define RTC_FOSC_WD        3'h4
`define RTC_SEL_INTERNAL   2'h3
`endif

// ===== rtl/rtc_pkg.sv
// types shared by the real-time clock / system timer files
// assumes rtc_cfg.svh supplies the numeric constants
package rtc_pkg;
   typedef logic [2:0] osc_sel_t;
   typedef logic [1:0] src_sel_t;
   // one-hot timer state
   typedef enum logic [1:0] {
      TMR_OFF = 2'b01,
      TMR_RUN = 2'b10
   } tmr_state_t;
endpackage

// ===== rtl/rtc_clock_select.sv
// timer clock source selection, producing one-cycle count enables
// assumes core_clk is faster than every source; ext_clock_in is a pin
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_clock_select (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              ext_clock_in,
   input  wire logic              cpu_clk_en,
   input  wire logic              int_osc_tick,
   input  wire logic              int_osc_div_tick,
   input  wire rtc_pkg::osc_sel_t cpu_oscillator_select,
   input  wire logic              rc_clock_option,
   input  wire rtc_pkg::src_sel_t source_select,
   output logic                   timer_tick
);
   import rtc_pkg::*;

   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic timer_tick_d;

   // two-stage synchroniser, third stage only for edge detection
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= ext_clock_in;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // selection only honoured when an internal oscillator runs the cpu
   wire ext_rise    = ext_s2_q & ~ext_s3_q;
   wire int_cpu_clk = (cpu_oscillator_select == `RTC_FOSC_RC) |
                      (cpu_oscillator_select == `RTC_FOSC_WD) |
                      rc_clock_option;
   wire int_pick    = (source_select == `RTC_SEL_INTERNAL);
   wire int_src     = rc_clock_option ? int_osc_tick : int_osc_div_tick;
   wire sel_src     = int_pick ? int_src : ext_rise;
   assign timer_tick_d = int_cpu_clk ? sel_src : cpu_clk_en;

   // registered enable pulse
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timer_tick <= 1'b0;
      end else begin
         timer_tick <= timer_tick_d;
      end
   end
endmodule

// ===== tb/tb_rtc_system_timer.sv
// self-checking bench for the real-time clock / system timer
// assumes rtc_cfg.svh and rtc_pkg are compiled ahead of this file
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module tb_rtc_system_timer;
   import rtc_pkg::*;
   logic              core_clk = 1'b0;
   logic              rst = 1'b1;
   logic [7:0]        sfr_addr = 8'h00;
   logic              sfr_wr = 1'b0;
   logic              sfr_rd = 1'b0;
   logic [7:0]        sfr_wdata = 8'h00;
   logic [7:0]        sfr_rdata;
   logic              ext_clock_in = 1'b0;
   logic              cpu_clk_en = 1'b0;
   logic              int_osc_tick = 1'b0;
   logic              int_osc_div_tick = 1'b0;
   osc_sel_t          cpu_oscillator_select = 3'h7;
   logic              rc_clock_option = 1'b0;
   logic              timer_power_down = 1'b0;
   logic              shared_wdog_timer_irq_enable = 1'b0;
   logic              global_irq_enable = 1'b0;
   logic              timer_irq;
   logic              wake_request;
   logic [22:0]       timer_count;
   logic [22:0]       img = {8'h12, 8'h34, 7'h7f};
   int                fails = 0;
   int                checked = 0;

   ////////////////////////////////////////////////////////////////////////
   // clock and design
   always #2.5 core_clk = ~core_clk;

   rtc_system_timer rtc_system_timer_inst (
      .core_clk                     (core_clk),
      .rst                          (rst),
      .sfr_addr                     (sfr_addr),
      .sfr_wr                       (sfr_wr),
      .sfr_rd                       (sfr_rd),
      .sfr_wdata                    (sfr_wdata),
      .sfr_rdata                    (sfr_rdata),
      .ext_clock_in                 (ext_clock_in),
      .cpu_clk_en                   (cpu_clk_en),
      .int_osc_tick                 (int_osc_tick),
      .int_osc_div_tick             (int_osc_div_tick),
      .cpu_oscillator_select        (cpu_oscillator_select),
      .rc_clock_option              (rc_clock_option),
      .timer_power_down             (timer_power_down),
      .shared_wdog_timer_irq_enable (shared_wdog_timer_irq_enable),
      .global_irq_enable            (global_irq_enable),
      .timer_irq                    (timer_irq),
      .wake_request                 (wake_request),
      .timer_count                  (timer_count)
   );

   ////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one write strobe, launched and dropped on falling edges
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge core_clk);
      sfr_wr = 1'b0;
   endtask

   // read strobe; data sampled the cycle after the read edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge core_clk);
      sfr_rd = 1'b0;
      check({24'h0, sfr_rdata}, {24'h0, exp});
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // source 0 cpu tick, 1 osc tick, 2 divided osc tick, 3 external pin
   task automatic tick(input int src, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge core_clk);
         case (src)
            0: cpu_clk_en = 1'b1;
            1: int_osc_tick = 1'b1;
            2: int_osc_div_tick = 1'b1;
            default: ext_clock_in = 1'b1;
         endcase
         if (src == 3) begin
            idle(4);
         end
         @(negedge core_clk);
         cpu_clk_en = 1'b0;
         int_osc_tick = 1'b0;
         int_osc_div_tick = 1'b0;
         ext_clock_in = 1'b0;
         if (src == 3) begin
            idle(4);
         end
      end
      idle(6);
   endtask

   task automatic results();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the under one thousand cycles the tests need
   initial begin
      #200000;
      fails++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      rd(`RTC_CTRL_ADDR, 8'h60);
      rd(`RTC_RELOAD_HI_ADDR, 8'h00);
      rd(8'h55, 8'h00);
      check(timer_count, 0);
      // load, count and stop with the cpu clock path
      wr(`RTC_RELOAD_HI_ADDR, 8'h12);
      wr(`RTC_RELOAD_LO_ADDR, 8'h34);
      rd(`RTC_RELOAD_LO_ADDR, 8'h34);
      wr(`RTC_CTRL_ADDR, 8'h61);
      idle(2);
      check(timer_count, img);
      tick(0, 5);
      check(timer_count, img - 5);
      tick(1, 3);
      check(timer_count, img - 5);
      wr(`RTC_CTRL_ADDR, 8'h01);
      rd(`RTC_CTRL_ADDR, 8'h61);
      timer_power_down = 1'b1;
      idle(3);
      check(timer_count, 0);
      rd(`RTC_CTRL_ADDR, 8'h61);
      timer_power_down = 1'b0;
      idle(3);
      check(timer_count, img);
      wr(`RTC_CTRL_ADDR, 8'h00);
      idle(3);
      check(timer_count, 0);
      // internal oscillator paths, select honoured
      cpu_oscillator_select = 3'h3;
      rc_clock_option = 1'b1;
      wr(`RTC_CTRL_ADDR, 8'h61);
      tick(1, 4);
      check(timer_count, img - 4);
      tick(0, 3);
      check(timer_count, img - 4);
      wr(`RTC_CTRL_ADDR, 8'h00);
      cpu_oscillator_select = 3'h4;
      rc_clock_option = 1'b0;
      wr(`RTC_CTRL_ADDR, 8'h61);
      tick(2, 4);
      check(timer_count, img - 4);
      tick(1, 2);
      check(timer_count, img - 4);
      // codes 00, 01, 10 take the external pin
      for (int s = 0; s < 3; s++) begin
         wr(`RTC_CTRL_ADDR, 8'h00);
         wr(`RTC_CTRL_ADDR, {1'b0, s[1:0], 5'h01});
         rd(`RTC_CTRL_ADDR, {1'b0, s[1:0], 5'h01});
         tick(3, 3);
         tick(2, 2);
         check(timer_count, img - 3);
      end
      // underflow with zero reload bytes
      wr(`RTC_CTRL_ADDR, 8'h00);
      wr(`RTC_RELOAD_HI_ADDR, 8'h00);
      wr(`RTC_RELOAD_LO_ADDR, 8'h00);
      cpu_oscillator_select = 3'h7;
      wr(`RTC_CTRL_ADDR, 8'h03);
      idle(2);
      check(timer_count, 23'h7f);
      tick(0, 127);
      check(timer_count, 0);
      check(wake_request, 1'b0);
      tick(0, 1);
      check(timer_count, 23'h7f);
      rd(`RTC_CTRL_ADDR, 8'h83);
      check(wake_request, 1'b1);
      // every combination of the three interrupt enables
      for (int i = 0; i < 8; i++) begin
         wr(`RTC_CTRL_ADDR, {6'b100000, i[0], 1'b1});
         shared_wdog_timer_irq_enable = i[1];
         global_irq_enable = i[2];
         idle(3);
         check(timer_irq, &i[2:0]);
      end
      rd(`RTC_CTRL_ADDR, 8'h83);
      wr(`RTC_CTRL_ADDR, 8'h03);
      idle(3);
      rd(`RTC_CTRL_ADDR, 8'h03);
      check({wake_request, timer_irq}, 0);
      // power-on reset in mid run
      wr(`RTC_RELOAD_HI_ADDR, 8'h5a);
      @(negedge core_clk);
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      rd(`RTC_CTRL_ADDR, 8'h60);
      rd(`RTC_RELOAD_HI_ADDR, 8'h00);
      check(timer_count, 0);
      results();
   end
endmodule
